// >>> logic/five_port_pin_mux.sv
// Port registers and pin multiplexing for six general ports with peripheral functions
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_defs.svh"

// Function
// - Port A eight pins, per-bit direction
// - Input pins get pull-up when option set
// - Port B eight pins, per-bit direction
// - Port C three pins, port or control
// - Port C carries sync or async serial
// - Async baud clock pin is input only
// - Port D three pins, edge interrupt inputs
// - Edge select rising, falling or both
// - One port D pin feeds capture trigger
// - Port E eight pins, key-return inputs
// - Port F four pins, per-bit direction
// - Port F carries timer clock and outputs
// - Active-low reset makes all pins input and clears latches
module five_port_pin_mux
  import pin_mux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire bus_req_s bus,
  output logic [7:0] rd_data,
  input wire logic [5:0][7:0] pad_in,
  output logic [5:0][7:0] pad_out,
  output logic [5:0][7:0] pad_oe,
  output logic [5:0][7:0] pad_pullup,
  input wire periph_tx_s periph_tx,
  output periph_rx_s periph_rx,
  output logic irq
);

  mux_state_s s_r;
  mux_state_s s_nxt;

  logic [5:0][7:0] sel_p;
  logic [5:0][7:0] cout_p;
  logic [5:0][7:0] drive_p;
  logic [5:0][7:0] hold_p;
  logic [5:0][7:0] level_p;
  logic [5:0][7:0] read_p;
  logic [2:0] ext_lvl;
  logic [2:0] ext_rise;
  logic [2:0] ext_fall;
  byte_t key_fall;
  byte_t events;
  logic [2:0] idx;

  // Pins that exist on each port
  function automatic byte_t port_mask(input logic [2:0] p);
    byte_t m;
    m = `MASK_NONE;
    if (p == `PORT_A || p == `PORT_B || p == `PORT_E) begin
      m = `MASK_8PIN;
    end else if (p == `PORT_C || p == `PORT_D) begin
      m = `MASK_3PIN;
    end else if (p == `PORT_F) begin
      m = `MASK_4PIN;
    end
    return m;
  endfunction

  // Pins that have a control function
  function automatic byte_t ctl_mask(input logic [2:0] p);
    byte_t m;
    m = port_mask(p);
    if (p == `PORT_A || p == `PORT_B) begin
      m = `MASK_NONE;
    end
    return m;
  endfunction

  // Page hit: high nibble matches and index names a port
  function automatic logic page_hit(input byte_t a, input logic [3:0] page);
    return (a[7:4] == page) && (a[3:0] < {1'b0, `PORT_COUNT});
  endfunction

  assign idx = bus.addr[2:0];

  // Control-mode routing per port
  always_comb begin
    sel_p = '0;
    cout_p = '0;
    drive_p = '0;
    hold_p = '0;
    sel_p[`PORT_C] = s_r.ctl[`PORT_C];
    cout_p[`PORT_C][`C_CLK_BIT] = periph_tx.sync_serial_clk_out;
    cout_p[`PORT_C][`C_TX_BIT] = s_r.ser_async ? periph_tx.async_serial_txd
                                               : periph_tx.sync_serial_dout;
    drive_p[`PORT_C][`C_CLK_BIT] = ~s_r.ser_async & periph_tx.sync_serial_clk_oe;
    hold_p[`PORT_C][`C_CLK_BIT] = s_r.ser_async;
    hold_p[`PORT_C][`C_RX_BIT] = 1'b1;
    sel_p[`PORT_D] = s_r.ctl[`PORT_D];
    hold_p[`PORT_D] = `MASK_3PIN;
    sel_p[`PORT_E] = s_r.ctl[`PORT_E];
    hold_p[`PORT_E] = `MASK_8PIN;
    sel_p[`PORT_F] = s_r.ctl[`PORT_F];
    cout_p[`PORT_F][`F_EVT_BIT] = periph_tx.byte_timer_out;
    cout_p[`PORT_F][`F_WIDE_BIT] = periph_tx.wide_timer_out;
  end

  // One pad cell per port
  for (genvar p = 0; p < 6; p++) begin : g_port
    port_pad_cell u_cell (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .mask(port_mask(3'(p))),
      .dir(s_r.dir[p]),
      .latch(s_r.latch[p]),
      .pullup_opt(s_r.pullup_option_reg[p]),
      .ctl_sel(sel_p[p]),
      .ctl_out(cout_p[p]),
      .ctl_drive(drive_p[p]),
      .ctl_hold(hold_p[p]),
      .pin_in(pad_in[p]),
      .pin_out(pad_out[p]),
      .pin_oe(pad_oe[p]),
      .pin_pu(pad_pullup[p]),
      .pin_level(level_p[p]),
      .port_read(read_p[p])
    );
  end

  // Synchronised levels handed to peripherals
  always_comb begin
    periph_rx = '0;
    periph_rx.sync_serial_din = level_p[`PORT_C][`C_RX_BIT] & ~s_r.ser_async;
    periph_rx.async_serial_rxd = level_p[`PORT_C][`C_RX_BIT] & s_r.ser_async;
    periph_rx.sync_serial_clk = level_p[`PORT_C][`C_CLK_BIT] & ~s_r.ser_async;
    periph_rx.async_baud_clk_in = level_p[`PORT_C][`C_CLK_BIT] & s_r.ser_async;
    periph_rx.ext_edge_irq_in = ext_lvl;
    periph_rx.capture_trigger_in = level_p[`PORT_D][`D_CAPT_BIT]
                                   & s_r.ctl[`PORT_D][`D_CAPT_BIT];
    periph_rx.key_return_in = level_p[`PORT_E] & s_r.ctl[`PORT_E];
    periph_rx.evt_counter_clk_in = level_p[`PORT_F][`F_EVT_BIT]
                                   & s_r.dir[`PORT_F][`F_EVT_BIT];
  end

  // Edge detection on interrupt and key inputs
  always_comb begin
    ext_lvl = level_p[`PORT_D][2:0] & s_r.ctl[`PORT_D][2:0];
    // rising, falling or both
    // Previous levels are ungated, so selecting or deselecting a pin is no edge
    ext_rise = ext_lvl & ~s_r.ext_prev & s_r.rise_en[2:0];
    ext_fall = ~level_p[`PORT_D][2:0] & s_r.ctl[`PORT_D][2:0] & s_r.ext_prev
               & s_r.fall_en[2:0];
    // key press is a falling edge
    key_fall = ~level_p[`PORT_E] & s_r.ctl[`PORT_E] & s_r.key_prev;
    events = `ZERO_BYTE;
    events[2:0] = ext_rise | ext_fall;
    events[`ST_KEY_BIT] = |key_fall;
  end

  // Register writes, reads and status update
  always_comb begin
    s_nxt = s_r;
    s_nxt.ext_prev = level_p[`PORT_D][2:0];
    s_nxt.key_prev = level_p[`PORT_E];
    s_nxt.rdata = `ZERO_BYTE;
    if (bus.wr) begin
      if (page_hit(bus.addr, `PAGE_LATCH)) begin
        s_nxt.latch[idx] = bus.wdata & port_mask(idx);
      end else if (page_hit(bus.addr, `PAGE_DIR)) begin
        s_nxt.dir[idx] = (bus.wdata & port_mask(idx)) | ~port_mask(idx);
      end else if (page_hit(bus.addr, `PAGE_CTL)) begin
        s_nxt.ctl[idx] = bus.wdata & ctl_mask(idx);
      end else if (bus.addr == `ADDR_PUO) begin
        s_nxt.pullup_option_reg = {2'h0, bus.wdata[5:0]};
      end else if (bus.addr == `ADDR_SER_MODE) begin
        s_nxt.ser_async = bus.wdata[0];
      end else if (bus.addr == `ADDR_RISE_EN) begin
        s_nxt.rise_en = bus.wdata & `MASK_3PIN;
      end else if (bus.addr == `ADDR_FALL_EN) begin
        s_nxt.fall_en = bus.wdata & `MASK_3PIN;
      end else if (bus.addr == `ADDR_MASK) begin
        s_nxt.mask = bus.wdata & `MASK_4PIN;
      end
    end
    if (bus.rd) begin
      if (page_hit(bus.addr, `PAGE_LATCH)) begin
        s_nxt.rdata = read_p[idx];
      end else if (page_hit(bus.addr, `PAGE_DIR)) begin
        s_nxt.rdata = s_r.dir[idx] & port_mask(idx);
      end else if (page_hit(bus.addr, `PAGE_CTL)) begin
        s_nxt.rdata = s_r.ctl[idx];
      end else if (bus.addr == `ADDR_PUO) begin
        s_nxt.rdata = s_r.pullup_option_reg;
      end else if (bus.addr == `ADDR_SER_MODE) begin
        s_nxt.rdata = {7'h00, s_r.ser_async};
      end else if (bus.addr == `ADDR_RISE_EN) begin
        s_nxt.rdata = s_r.rise_en;
      end else if (bus.addr == `ADDR_FALL_EN) begin
        s_nxt.rdata = s_r.fall_en;
      end else if (bus.addr == `ADDR_STATUS) begin
        s_nxt.rdata = s_r.status;
        s_nxt.status = `ZERO_BYTE;
      end else if (bus.addr == `ADDR_MASK) begin
        s_nxt.rdata = s_r.mask;
      end
    end
    // New events win over the read clear
    s_nxt.status = s_nxt.status | events;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.dir <= {6{`DIR_RST}};
      s_r.latch <= {6{`LATCH_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Read data and interrupt level
  assign rd_data = s_r.rdata;
  assign irq = |(s_r.status & s_r.mask);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence ext0_rise_seen;
    s_r.ctl[`PORT_D][0] && s_r.rise_en[0] && !s_r.ext_prev[0] && ext_lvl[0];
  endsequence

  sequence key0_press;
    s_r.key_prev[0] && s_r.ctl[`PORT_E][0] && !level_p[`PORT_E][0];
  endsequence

  a_port_a_drive: assert property (pad_oe[`PORT_A] == ~s_r.dir[`PORT_A])
    else $error("port A drive does not follow direction");

  a_pullup_input_only: assert property (
    (pad_pullup[`PORT_A] == ({8{s_r.pullup_option_reg[0]}} & s_r.dir[`PORT_A])))
    else $error("port A pull-up does not follow option and direction");

  a_port_b_drive: assert property ($changed(s_r.dir[`PORT_B])
    |-> pad_oe[`PORT_B] == ~s_r.dir[`PORT_B])
    else $error("port B drive missed a direction change");

  a_port_c_width: assert property (pad_oe[`PORT_C][7:3] == 5'h00
    && (!s_r.ctl[`PORT_C][2] || !pad_oe[`PORT_C][2]))
    else $error("port C drives a missing or input-only pin");

  a_serial_tx_route: assert property (s_r.ctl[`PORT_C][1] && !s_r.dir[`PORT_C][1]
    |-> pad_out[`PORT_C][1] == (s_r.ser_async ? periph_tx.async_serial_txd
                                               : periph_tx.sync_serial_dout))
    else $error("serial transmit pin carries wrong source");

  a_baud_clk_input: assert property (s_r.ctl[`PORT_C][0] && s_r.ser_async
    |-> !pad_oe[`PORT_C][0])
    else $error("baud clock pin driven");

  a_port_d_drive: assert property (pad_oe[`PORT_D] ==
    (~s_r.dir[`PORT_D] & ~s_r.ctl[`PORT_D] & `MASK_3PIN))
    else $error("port D drive wrong");

  a_edge_sets_irq: assert property (ext0_rise_seen ##0 s_r.mask[0]
    |=> s_r.status[0] && irq)
    else $error("rising edge did not raise interrupt");

  a_capture_follows: assert property ((s_r.ctl[`PORT_D][2] && pad_in[`PORT_D][2])[*3]
    |-> periph_rx.capture_trigger_in)
    else $error("capture trigger does not follow pin");

  a_key_press_flag: assert property (key0_press |=> s_r.status[`ST_KEY_BIT])
    else $error("key press not flagged");

  a_port_f_drive: assert property (!s_r.dir[`PORT_F][3] |-> pad_oe[`PORT_F][3])
    else $error("port F output pin not driven");

  a_wide_timer_out: assert property (s_r.ctl[`PORT_F][1] && !s_r.dir[`PORT_F][1]
    |-> pad_out[`PORT_F][1] == periph_tx.wide_timer_out && pad_oe[`PORT_F][1])
    else $error("wide timer output not on pin");

  a_no_pullup_driven: assert property ((pad_pullup & pad_oe) == '0)
    else $error("pull-up on a driven pin");

  a_read_latch: assert property (bus.rd && bus.addr == {`PAGE_LATCH, 1'b0, `PORT_A}
    && s_r.dir[`PORT_A] == `ZERO_BYTE |=> rd_data == $past(s_r.latch[`PORT_A]))
    else $error("output port read is not the latch");

endmodule
`default_nettype wire

// >>> logic/pin_mux_defs.svh
// Address map, reset values, bit positions and masks of the port and pin multiplexer
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

// Number of ports and index of each port
`define PORT_COUNT 3'h6
`define PORT_A 3'h0
`define PORT_B 3'h1
`define PORT_C 3'h2
`define PORT_D 3'h3
`define PORT_E 3'h4
`define PORT_F 3'h5

// Pins present on each port
`define MASK_8PIN 8'hFF
`define MASK_3PIN 8'h07
`define MASK_4PIN 8'h0F
`define MASK_NONE 8'h00

// Register pages, indexed by the low address nibble
`define PAGE_LATCH 4'h0
`define PAGE_DIR 4'h1
`define PAGE_CTL 4'h3

// Single registers
`define ADDR_PUO 8'h20
`define ADDR_SER_MODE 8'h40
`define ADDR_RISE_EN 8'h41
`define ADDR_FALL_EN 8'h42
`define ADDR_STATUS 8'h50
`define ADDR_MASK 8'h51

// Reset values: all pins input, latches low, pull-ups off, port mode
`define DIR_RST 8'hFF
`define LATCH_RST 8'h00
`define ZERO_BYTE 8'h00

// Pin positions of the multiplexed functions
`define C_CLK_BIT 0
`define C_TX_BIT 1
`define C_RX_BIT 2
`define D_CAPT_BIT 2
`define F_EVT_BIT 0
`define F_WIDE_BIT 1

// Status bits: external edges in 2:0, key return in 3
`define ST_KEY_BIT 3
`define EXT_COUNT 3

`endif

// >>> logic/pin_mux_pkg.sv
// Types shared by the port and pin multiplexer
`default_nettype none

package pin_mux_pkg;

  typedef logic [7:0] byte_t;

  // Register port request
  typedef struct packed {
    byte_t addr;
    byte_t wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  // Signals from on-chip peripherals towards the pins
  typedef struct packed {
    logic sync_serial_dout;
    logic sync_serial_clk_out;
    logic sync_serial_clk_oe;
    logic async_serial_txd;
    logic byte_timer_out;
    logic wide_timer_out;
  } periph_tx_s;

  // Signals from the pins towards on-chip peripherals
  typedef struct packed {
    logic sync_serial_din;
    logic sync_serial_clk;
    logic async_serial_rxd;
    logic async_baud_clk_in;
    logic [2:0] ext_edge_irq_in;
    logic capture_trigger_in;
    byte_t key_return_in;
    logic evt_counter_clk_in;
  } periph_rx_s;

  // State of one pad cell: two-stage synchroniser
  typedef struct packed {
    byte_t meta;
    byte_t level;
  } pad_state_s;

  // State of the multiplexer core
  typedef struct packed {
    byte_t [5:0] latch;
    byte_t [5:0] dir;
    byte_t pullup_option_reg;
    byte_t [5:0] ctl;
    logic ser_async;
    byte_t rise_en;
    byte_t fall_en;
    byte_t status;
    byte_t mask;
    byte_t rdata;
    logic [2:0] ext_prev;
    byte_t key_prev;
  } mux_state_s;

endpackage

`default_nettype wire

// >>> logic/port_pad_cell.sv
// One port of up to eight pins: drive, pull-up, input synchroniser and read-back
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_defs.svh"

module port_pad_cell
  import pin_mux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire byte_t mask,
  input wire byte_t dir,
  input wire byte_t latch,
  input wire logic pullup_opt,
  input wire byte_t ctl_sel,
  input wire byte_t ctl_out,
  input wire byte_t ctl_drive,
  input wire byte_t ctl_hold,
  input wire byte_t pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pu,
  output logic [7:0] pin_level,
  output logic [7:0] port_read
);

  pad_state_s s_r;
  pad_state_s s_nxt;

  // Drive when direction says output or the control function forces it, unless the control function holds the pin
  always_comb begin
    pin_oe = mask & ~(ctl_sel & ctl_hold) & (~dir | (ctl_sel & ctl_drive));
    pin_out = mask & ((ctl_sel & ctl_out) | (~ctl_sel & latch));
    pin_pu = {8{pullup_opt}} & mask & ~pin_oe;
  end

  // Two flops per pin; only the second stage is looked at
  always_comb begin
    s_nxt = s_r;
    s_nxt.meta = pin_in & mask;
    s_nxt.level = s_r.meta;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    pin_level = s_r.level;
    port_read = mask & ((~dir & latch) | (dir & s_r.level));
  end

endmodule
`default_nettype wire

// >>> testbench/board_model.sv
// Board model: resolves each pad from device drive, board drive and pull-up
`timescale 1ns/1ps
`default_nettype none

module board_model
  import pin_mux_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [5:0][7:0] pad_out,
  input wire logic [5:0][7:0] pad_oe,
  input wire logic [5:0][7:0] pad_pullup,
  input wire logic [5:0][7:0] ext_val,
  input wire logic [5:0][7:0] ext_en,
  output logic [5:0][7:0] pad_in
);
  logic [5:0][7:0] last_r;

  // Keep the previous level so an undriven pad keeps toggling
  always_ff @(posedge clk_sys) begin
    last_r <= pad_in;
  end

  // Device drive first, then board drive, then pull-up, else floating
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pad_oe[p][b]) begin
          pad_in[p][b] = pad_out[p][b];
        end else if (ext_en[p][b]) begin
          pad_in[p][b] = ext_val[p][b];
        end else if (pad_pullup[p][b]) begin
          pad_in[p][b] = 1'b1;
        end else begin
          pad_in[p][b] = ~last_r[p][b];
        end
      end
    end
  end
endmodule

`default_nettype wire

// >>> testbench/five_port_pin_mux_tb_top.sv
// Self-checking testbench for the port and pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module five_port_pin_mux_tb_top
  import pin_mux_pkg::*;
;
  typedef struct packed {
    logic is_rd;
    byte_t a;
    byte_t d;
  } row_s;

  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  bus_req_s bus = '0;
  periph_tx_s periph_tx = '0;
  logic [7:0] rd_data;
  logic [5:0][7:0] pad_in;
  logic [5:0][7:0] pad_out;
  logic [5:0][7:0] pad_oe;
  logic [5:0][7:0] pad_pullup;
  logic [5:0][7:0] ext_val = {6{8'h5A}};
  logic [5:0][7:0] ext_en = '1;
  periph_rx_s periph_rx;
  logic irq;
  int fail_count = 0;
  int checks = 0;
  byte_t d;

  // Register traffic and expected read-backs, board drives 5A on all pads
  row_s rows [0:16] = '{
    '{1'h0, 8'h10, 8'h0F}, '{1'h0, 8'h00, 8'hC3}, '{1'h1, 8'h00, 8'hCA},
    '{1'h0, 8'h11, 8'h00}, '{1'h0, 8'h01, 8'h96}, '{1'h1, 8'h01, 8'h96},
    '{1'h1, 8'h12, 8'h07}, '{1'h1, 8'h02, 8'h02}, '{1'h0, 8'h15, 8'h0E},
    '{1'h0, 8'h05, 8'h01}, '{1'h1, 8'h05, 8'h0B}, '{1'h0, 8'h20, 8'h3F},
    '{1'h1, 8'h20, 8'h3F}, '{1'h0, 8'h60, 8'hFF}, '{1'h1, 8'h60, 8'h00},
    '{1'h1, 8'h30, 8'h00}, '{1'h1, 8'h11, 8'h00}
  };

  five_port_pin_mux five_port_pin_mux_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus(bus), .rd_data(rd_data),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .periph_tx(periph_tx), .periph_rx(periph_rx), .irq(irq)
  );

  board_model board_model_inst (
    .clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in)
  );

  // System clock, 20 ns period
  always #10 clk_sys = ~clk_sys;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One-cycle write strobe
  task automatic wr(input byte_t a, input byte_t v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input byte_t a, output byte_t v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1 v = rd_data;
  endtask

  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    cyc(8);
    chk("oe_in_reset", pad_oe, 48'h0);
    arst_n <= 1'b1;
    rd(8'h10, d);
    chk("dir_a_reset", d, 8'hFF);
    foreach (rows[i]) begin
      if (rows[i].is_rd) begin
        rd(rows[i].a, d);
        chk("row_read", d, rows[i].d);
      end else begin
        wr(rows[i].a, rows[i].d);
      end
    end
    chk("oe_a", pad_oe[0], 8'hF0);
    chk("out_b", pad_out[1], 8'h96);
    chk("pu_a", pad_pullup[0], 8'h0F);
    chk("pu_b", pad_pullup[1], 8'h00);
    // Board releases port A inputs, pull-up must hold them high
    @(posedge clk_sys);
    ext_en[0] <= 8'hF0;
    cyc(4);
    rd(8'h00, d);
    chk("float_a", d, 8'hCF);
    // Edge interrupts: pin0 rising, pin1 falling, pin2 both
    wr(8'h33, 8'h07);
    wr(8'h41, 8'h05);
    wr(8'h42, 8'h06);
    wr(8'h51, 8'h00);
    ext_val[3] <= 8'h00;
    cyc(5);
    rd(8'h50, d);
    ext_val[3] <= 8'h07;
    cyc(5);
    #1 chk("irq_masked", irq, 1'b0);
    chk("ext_in", periph_rx.ext_edge_irq_in, 3'h7);
    chk("capture", periph_rx.capture_trigger_in, 1'b1);
    wr(8'h51, 8'h0F);
    #1 chk("irq_on", irq, 1'b1);
    rd(8'h50, d);
    chk("rise_st", d, 8'h05);
    chk("irq_clr", irq, 1'b0);
    ext_val[3] <= 8'h00;
    cyc(5);
    rd(8'h50, d);
    chk("fall_st", d, 8'h06);
    // Key return on port E pin0 falling
    wr(8'h34, 8'h01);
    ext_val[4] <= 8'hFF;
    cyc(5);
    #1 chk("key_in", periph_rx.key_return_in, 8'h01);
    rd(8'h50, d);
    ext_val[4] <= 8'hFE;
    cyc(5);
    rd(8'h50, d);
    chk("key_st", d, 8'h08);
    // direction and latch set for serial
    wr(8'h32, 8'h07);
    wr(8'h12, 8'h05);
    wr(8'h02, 8'h00);
    periph_tx.sync_serial_dout <= 1'b1;
    cyc(1);
    #1 chk("oe_c_sync", pad_oe[2], 8'h02);
    chk("dout_c", pad_out[2][1], 1'b1);
    wr(8'h40, 8'h01);
    periph_tx.sync_serial_clk_oe <= 1'b1;
    ext_val[2] <= 8'h05;
    cyc(4);
    #1 chk("txd_c", pad_out[2][1], 1'b0);
    chk("baud_in_only", pad_oe[2][0], 1'b0);
    chk("baud_clk", periph_rx.async_baud_clk_in, 1'b1);
    chk("rxd", periph_rx.async_serial_rxd, 1'b1);
    // Port F timer functions
    wr(8'h35, 8'h03);
    wr(8'h15, 8'h0D);
    periph_tx.wide_timer_out <= 1'b1;
    ext_val[5] <= 8'h01;
    cyc(4);
    #1 chk("wide_out", pad_out[5][1], 1'b1);
    chk("evt_clk", periph_rx.evt_counter_clk_in, 1'b1);
    // Reset in mid-run
    @(posedge clk_sys);
    arst_n <= 1'b0;
    #1 chk("oe_mid_rst", pad_oe, 48'h0);
    chk("pu_mid_rst", pad_pullup, 48'h0);
    cyc(8);
    arst_n <= 1'b1;
    rd(8'h20, d);
    chk("puo_rst", d, 8'h00);
    give_verdict();
  end
endmodule

`default_nettype wire
